/* logic/ccr_defines.vh */
// Purpose: constants for the processor control register bank
// Assumes: included by bare name from ccr_regfile.v
// Notes:   indices are control register numbers 0..31
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH

`define CCR_IDX_STATE      5'h00
`define CCR_IDX_ESAVED     5'h01
`define CCR_IDX_BSAVED     5'h02
`define CCR_IDX_IENABLE    5'h03
`define CCR_IDX_IPENDING   5'h04
`define CCR_IDX_CPUID      5'h05
`define CCR_IDX_CAUSE      5'h07
`define CCR_IDX_PTADDR     5'h08
`define CCR_IDX_TLBACC     5'h09
`define CCR_IDX_TLBMISC    5'h0A
`define CCR_IDX_FAULTADDR  5'h0C
`define CCR_IDX_CORECFG    5'h0D
`define CCR_IDX_MPUBASE    5'h0E
`define CCR_IDX_MPUACC     5'h0F

// state word field positions
`define CCR_BIT_GIE        0
`define CCR_BIT_PRIV       1
`define CCR_BIT_EXC        2

// cause field sits in bits 6:2
`define CCR_CAUSE_LSB      2
`define CCR_CAUSE_MSB      6

`define CCR_STATE_RESET    3'h0
`define CCR_CAUSE_RESET    5'h00

`endif

/* logic/ccr_regfile.v */
// Purpose: control register bank of a soft processor core
// Assumes: pipeline drives one-cycle request strobes on sys_clk
// Notes:   mmu/mpu registers 8-10 and 13-15 are plain storage only
`timescale 1ns/1ps
`include "ccr_defines.vh"

module ccr_regfile #(
  parameter        HAS_MMU   = 0,
  parameter        HAS_MPU   = 0,
  parameter        EXTRA_EXC = 0,
  parameter [31:0] CPU_ID    = 32'h00000000 // arbitrary value
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        rd_req,
  input  wire        wr_req,
  input  wire [4:0]  reg_index,
  input  wire [31:0] wr_data,
  input  wire        exc_take,
  input  wire [4:0]  exc_cause_code,
  input  wire [31:0] exc_fault_addr,
  input  wire        brk_take,
  input  wire        exc_return,
  input  wire        brk_return,
  input  wire [31:0] irq_lines,
  output reg  [31:0] rd_data,
  output reg         rd_valid,
  output reg         access_denied,
  output reg         irq_request,
  output reg         user_mode,
  output reg         global_interrupt_enable,
  output reg         exception_active_flag
);

  localparam HAS_PRIV  = (HAS_MMU != 0) || (HAS_MPU != 0);
  localparam HAS_EXTRA = HAS_PRIV || (EXTRA_EXC != 0);

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [2:0]  esaved_q;
  reg  [2:0]  bsaved_q;
  reg  [31:0] ienable_q;
  reg  [4:0]  cause_q;
  reg  [31:0] faddr_q;
  reg  [31:0] ptaddr_q;
  reg  [31:0] tlbacc_q;
  reg  [31:0] tlbmisc_q;
  reg  [31:0] corecfg_q;
  reg  [31:0] mpubase_q;
  reg  [31:0] mpuacc_q;
  reg  [31:0] irq_meta_q;
  reg  [31:0] irq_sync_q;
  reg  [31:0] rd_mux;
  reg  [2:0]  wr_state;
  wire        super_mode;
  wire        rd_ok;
  wire        wr_ok;
  wire        mmu_live;
  wire        mpu_live;
  wire [31:0] idx_hit;
  wire [31:0] idx_live;
  wire        we_state;
  wire        we_esaved;
  wire        we_bsaved;
  wire        we_ienable;
  wire        we_ptaddr;
  wire        we_tlbacc;
  wire        we_tlbmisc;
  wire        we_corecfg;
  wire        we_mpubase;
  wire        we_mpuacc;

  // privilege bit only takes effect with a protection unit present
  assign super_mode = ~state_q[`CCR_BIT_PRIV];
  assign rd_ok      = rd_req & super_mode;
  assign wr_ok      = wr_req & super_mode;
  assign mmu_live   = (HAS_MMU != 0);
  assign mpu_live   = (HAS_MPU != 0);

  // presence map of the 32-entry index space; a clear bit behaves as
  // reserved, so absent units need no case of their own in the strobes
  assign idx_live[5:0]   = 6'h3F;
  assign idx_live[6]     = 1'b0;
  assign idx_live[7]     = 1'b1;
  assign idx_live[10:8]  = {3{mmu_live}};
  assign idx_live[11]    = 1'b0;
  assign idx_live[12]    = 1'b1;
  assign idx_live[15:13] = {3{mpu_live}};
  assign idx_live[31:16] = 16'h0000;

  // one-hot index decode; the shift stays 32 bits wide
  assign idx_hit = (32'h00000001 << reg_index) & idx_live;

  // write strobes; read-only and reserved places get none
  assign we_state   = wr_ok & idx_hit[`CCR_IDX_STATE];
  assign we_esaved  = wr_ok & idx_hit[`CCR_IDX_ESAVED];
  assign we_bsaved  = wr_ok & idx_hit[`CCR_IDX_BSAVED];
  assign we_ienable = wr_ok & idx_hit[`CCR_IDX_IENABLE];
  assign we_ptaddr  = wr_ok & idx_hit[`CCR_IDX_PTADDR];
  assign we_tlbacc  = wr_ok & idx_hit[`CCR_IDX_TLBACC];
  assign we_tlbmisc = wr_ok & idx_hit[`CCR_IDX_TLBMISC];
  assign we_corecfg = wr_ok & idx_hit[`CCR_IDX_CORECFG];
  assign we_mpubase = wr_ok & idx_hit[`CCR_IDX_MPUBASE];
  assign we_mpuacc  = wr_ok & idx_hit[`CCR_IDX_MPUACC];

  // mask a written state value down to bits this build implements
  always @* begin
    wr_state = 3'h0;
    wr_state[`CCR_BIT_GIE] = wr_data[`CCR_BIT_GIE];
    if (HAS_PRIV) begin
      wr_state[`CCR_BIT_PRIV] = wr_data[`CCR_BIT_PRIV];
    end
    if (mmu_live) begin
      wr_state[`CCR_BIT_EXC] = wr_data[`CCR_BIT_EXC];
    end
  end

  // state word next value; hardware events take priority over a write
  // so a break or exception in the write cycle is never lost
  always @* begin
    state_d = state_q;
    if (we_state) begin
      state_d = wr_state;
    end
    if (exc_return) begin
      state_d = esaved_q;
    end
    if (brk_return) begin
      state_d = bsaved_q;
    end
    if (exc_take || brk_take) begin
      // entry drops to supervisor with interrupts off
      state_d[`CCR_BIT_GIE]  = 1'b0;
      state_d[`CCR_BIT_PRIV] = 1'b0;
      state_d[`CCR_BIT_EXC]  = mmu_live;
    end
  end

  // state word; reset leaves supervisor mode with interrupts off
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= `CCR_STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // exception shadow; an entry in a write cycle wins over the write
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      esaved_q <= `CCR_STATE_RESET;
    end else if (exc_take) begin
      esaved_q <= state_q;
    end else if (we_esaved) begin
      esaved_q <= wr_state;
    end
  end

  // break shadow; same priority as the exception shadow
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bsaved_q <= `CCR_STATE_RESET;
    end else if (brk_take) begin
      bsaved_q <= state_q;
    end else if (we_bsaved) begin
      bsaved_q <= wr_state;
    end
  end

  // line enables, full width so any line can be masked alone
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ienable_q <= 32'h00000000;
    end else if (we_ienable) begin
      ienable_q <= wr_data;
    end
  end

  // cause is read-only to software; only non-break entry loads it,
  // and without extra information both stay at their reset value
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cause_q <= `CCR_CAUSE_RESET;
      faddr_q <= 32'h00000000;
    end else if (exc_take && HAS_EXTRA) begin
      cause_q <= exc_cause_code;
      faddr_q <= exc_fault_addr;
    end
  end

  // page table address: storage only, present with the mmu
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptaddr_q <= 32'h00000000;
    end else if (we_ptaddr) begin
      ptaddr_q <= wr_data;
    end
  end

  // translation entry access: storage only, present with the mmu
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tlbacc_q <= 32'h00000000;
    end else if (we_tlbacc) begin
      tlbacc_q <= wr_data;
    end
  end

  // translation misc control: storage only, present with the mmu
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tlbmisc_q <= 32'h00000000;
    end else if (we_tlbmisc) begin
      tlbmisc_q <= wr_data;
    end
  end

  // core configuration: storage only, present with the mpu
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      corecfg_q <= 32'h00000000;
    end else if (we_corecfg) begin
      corecfg_q <= wr_data;
    end
  end

  // protection region base: storage only, present with the mpu
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mpubase_q <= 32'h00000000;
    end else if (we_mpubase) begin
      mpubase_q <= wr_data;
    end
  end

  // protection region access: storage only, present with the mpu
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mpuacc_q <= 32'h00000000;
    end else if (we_mpuacc) begin
      mpuacc_q <= wr_data;
    end
  end

  // irq lines come from other logic of unknown timing: two-stage sync
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_meta_q <= 32'h00000000;
      irq_sync_q <= 32'h00000000;
    end else begin
      irq_meta_q <= irq_lines;
      irq_sync_q <= irq_meta_q;
    end
  end

  // read decode over the 32-entry index space
  always @* begin
    rd_mux = 32'h00000000;
    case (reg_index)
      `CCR_IDX_STATE:     rd_mux = {29'h0, state_q};
      `CCR_IDX_ESAVED:    rd_mux = {29'h0, esaved_q};
      `CCR_IDX_BSAVED:    rd_mux = {29'h0, bsaved_q};
      `CCR_IDX_IENABLE:   rd_mux = ienable_q;
      `CCR_IDX_IPENDING:  rd_mux = irq_sync_q;
      `CCR_IDX_CPUID:     rd_mux = CPU_ID;
      `CCR_IDX_CAUSE: begin
        if (HAS_EXTRA) begin
          rd_mux[`CCR_CAUSE_MSB:`CCR_CAUSE_LSB] = cause_q;
        end
      end
      `CCR_IDX_PTADDR:    rd_mux = mmu_live ? ptaddr_q : 32'h0;
      `CCR_IDX_TLBACC:    rd_mux = mmu_live ? tlbacc_q : 32'h0;
      `CCR_IDX_TLBMISC:   rd_mux = mmu_live ? tlbmisc_q : 32'h0;
      `CCR_IDX_FAULTADDR: rd_mux = HAS_EXTRA ? faddr_q : 32'h0;
      `CCR_IDX_CORECFG:   rd_mux = mpu_live ? corecfg_q : 32'h0;
      `CCR_IDX_MPUBASE:   rd_mux = mpu_live ? mpubase_q : 32'h0;
      `CCR_IDX_MPUACC:    rd_mux = mpu_live ? mpuacc_q : 32'h0;
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // read answer one cycle after the request; zero outside that cycle
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= 32'h00000000;
    end else begin
      rd_valid <= rd_ok;
      rd_data  <= rd_ok ? rd_mux : 32'h00000000;
    end
  end

  // user-mode attempt flagged so the pipeline can trap it
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      access_denied <= 1'b0;
    end else begin
      access_denied <= (rd_req | wr_req) & ~super_mode;
    end
  end

  // uses the synced pending so the request matches what is read back;
  // taken from the next state so it moves with the enable output
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= state_d[`CCR_BIT_GIE] &
                     (|(ienable_q & irq_sync_q));
    end
  end

  // status mirrors, flopped from the next state word
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      user_mode               <= 1'b0;
      global_interrupt_enable <= 1'b0;
      exception_active_flag   <= 1'b0;
    end else begin
      user_mode               <= state_d[`CCR_BIT_PRIV];
      global_interrupt_enable <= state_d[`CCR_BIT_GIE];
      exception_active_flag   <= state_d[`CCR_BIT_EXC];
    end
  end

endmodule

/* verif/ccr_monitor.sv */
// Purpose: port checks of the control register bank
// Assumes: bank built with the mmu present
// Notes:   status outputs follow their cause by one edge
`timescale 1ns/1ps
module ccr_monitor (
  input wire        sys_clk,
  input wire        rst,
  input wire        rd_req,
  input wire        wr_req,
  input wire [4:0]  reg_index,
  input wire [31:0] wr_data,
  input wire        exc_take,
  input wire        brk_take,
  input wire        exc_return,
  input wire        brk_return,
  input wire [31:0] rd_data,
  input wire        rd_valid,
  input wire        access_denied,
  input wire        irq_request,
  input wire        user_mode,
  input wire        global_interrupt_enable,
  input wire        exception_active_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // any state event outranks a software write, so exclude them all
  wire evt = exc_take | brk_take | exc_return | brk_return;

  property p_rd; rd_req && !user_mode |=> rd_valid && !access_denied;
  endproperty
  a_rd: assert property (p_rd) else $error("read lost");
  property p_deny; (rd_req || wr_req) && user_mode |=> access_denied
    && !rd_valid; endproperty
  a_deny: assert property (p_deny) else $error("user access");
  property p_ent; exc_take || brk_take |=> exception_active_flag
    && !user_mode && !global_interrupt_enable; endproperty
  a_ent: assert property (p_ent) else $error("entry state");
  // both outputs are flopped from the same next state, so same cycle
  property p_gie; !global_interrupt_enable |-> !irq_request; endproperty
  a_gie: assert property (p_gie) else $error("irq masked");
  property p_rsv; rd_req && !user_mode && (reg_index[4] || reg_index == 5'h06
    || reg_index == 5'h0B) |=> rd_data == 32'h00000000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read");
  property p_idle; !rd_valid |-> rd_data == 32'h00000000; endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  property p_rst; $past(rst) |-> !user_mode && !global_interrupt_enable
    && !exception_active_flag; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_wr; wr_req && !user_mode && !evt && reg_index == 5'h00
    && wr_data[1:0] == 2'b01 |=> global_interrupt_enable && !user_mode;
  endproperty
  a_wr: assert property (p_wr) else $error("state write");
endmodule

/* verif/ccr_pipe_model.sv */
// Purpose: pipeline side issuing control register moves
// Assumes: tasks are entered just after a rising edge
// Notes:   lines are scrambled between requests, never left stale
`timescale 1ns/1ps
module ccr_pipe_model (
  output reg         rd_req,
  output reg         wr_req,
  output reg  [4:0]  reg_index,
  output reg  [31:0] wr_data,
  input  wire        sys_clk,
  input  wire [31:0] rd_data
);
  initial begin
    rd_req = 1'b0;
    wr_req = 1'b0;
    reg_index = 5'h00;
    wr_data = 32'h00000000;
  end
  // one-cycle strobe; caller keeps undefined bits zero
  task ctl_wr(input [4:0] k, input [31:0] v);
    begin
      @(posedge sys_clk);
      #1 {wr_req, reg_index, wr_data} = {1'b1, k, v};
      @(posedge sys_clk);
      #1 {wr_req, reg_index, wr_data} = {1'b0, ~k, ~v};
    end
  endtask
  // answer stands one cycle, so it is taken right after the edge
  task ctl_rd(input [4:0] k, output [31:0] v);
    begin
      @(posedge sys_clk);
      #1 {rd_req, reg_index} = {1'b1, k};
      @(posedge sys_clk);
      #1 {rd_req, reg_index} = {1'b0, ~k};
      v = rd_data;
    end
  endtask
endmodule

/* verif/cpu_control_register_file_bench.sv */
// Purpose: self-checking bench of the control register bank
// Assumes: mmu and mpu configured, identifier set by the bench
// Notes:   all driving happens 1 ns after a rising edge
`timescale 1ns/1ps
module cpu_control_register_file_bench;
  reg         sys_clk, rst, exc_take, brk_take, exc_return, brk_return;
  reg  [4:0]  exc_cause_code;
  reg  [31:0] exc_fault_addr, irq_lines, d, q, seed;
  wire        rd_req, wr_req, rd_valid, access_denied, irq_request;
  wire        user_mode, global_interrupt_enable, exception_active_flag;
  wire [4:0]  reg_index;
  wire [31:0] wr_data, rd_data;
  integer     errors, n_tests, i;
  localparam [31:0] ID_VAL = 32'h5A3C0F96; // arbitrary value

  ccr_regfile #(.HAS_MMU(1), .HAS_MPU(1), .CPU_ID(ID_VAL)) uut (
    .sys_clk(sys_clk), .rst(rst), .rd_req(rd_req), .wr_req(wr_req),
    .reg_index(reg_index), .wr_data(wr_data), .exc_take(exc_take),
    .exc_cause_code(exc_cause_code), .exc_fault_addr(exc_fault_addr),
    .brk_take(brk_take), .exc_return(exc_return), .brk_return(brk_return),
    .irq_lines(irq_lines), .rd_data(rd_data), .rd_valid(rd_valid),
    .access_denied(access_denied), .irq_request(irq_request),
    .user_mode(user_mode), .global_interrupt_enable(global_interrupt_enable),
    .exception_active_flag(exception_active_flag));
  ccr_pipe_model pipe (.sys_clk(sys_clk), .rd_req(rd_req), .wr_req(wr_req),
    .reg_index(reg_index), .wr_data(wr_data), .rd_data(rd_data));

  function [31:0] st();
    st = {29'h0, exception_active_flag, user_mode, global_interrupt_enable};
  endfunction
  // read-only and reserved places: pending shows live lines and the
  // identifier its constant, everything else reads zero
  function [31:0] exp_ro(input integer k);
    exp_ro = (k == 4) ? irq_lines : (k == 5) ? ID_VAL : 32'h00000000;
  endfunction
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask
  // leading tick keeps two pulses from touching in one time step
  task ev(input [3:0] m);
    begin
      tick(1);
      {exc_take, brk_take, exc_return, brk_return} = m;
      tick(1);
      {exc_take, brk_take, exc_return, brk_return} = 4'h0;
    end
  endtask
  task close_out;
    begin
      if (errors == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // the sequence needs well under 2000 cycles; 20000 means a hang
  initial begin
    #200000;
    errors = errors + 1;
    close_out;
  end
  initial begin
    {seed, errors, n_tests, rst, exc_cause_code} = {32'h6A56, 64'h0, 6'h20};
    {exc_take, brk_take, exc_return, brk_return} = 4'h0;
    {exc_fault_addr, irq_lines} = 64'h0;
    tick(4);
    rst = 1'b0;
    chk("reset", st(), 32'h00000000);
    for (i = 0; i < 12; i = i + 1) begin
      d = $random(seed);
      if (i % 3 != 2) d = d & 32'h00000007;
      pipe.ctl_wr(i % 3 + 1, d);
      pipe.ctl_rd(i % 3 + 1, q);
      chk("rw", q, d);
    end
    // mmu and mpu storage places hold whatever is written
    for (i = 8; i < 16; i = i + 1) if (i != 11 && i != 12) begin
      d = $random(seed);
      pipe.ctl_wr(i, d);
      pipe.ctl_rd(i, q);
      chk("unit", q, d);
    end
    irq_lines = $random(seed);
    for (i = 4; i < 32; i = i + 1) if (i < 7 || i == 11 || i > 15) begin
      pipe.ctl_wr(i, 32'hFFFFFFFF);
      pipe.ctl_rd(i, q);
      chk("ro", q, exp_ro(i));
    end
    pipe.ctl_wr(3, irq_lines);
    tick(3);
    chk("irq_off", {31'h0, irq_request}, 32'h00000000);
    pipe.ctl_wr(0, 32'h00000001);
    tick(2);
    chk("irq_on", {31'h0, irq_request}, {31'h0, |irq_lines});
    pipe.ctl_wr(3, ~irq_lines);
    tick(2);
    chk("irq_mask", {31'h0, irq_request}, 32'h00000000);
    d = $random(seed);
    exc_cause_code = d[4:0];
    ev(4'h8);
    chk("exc", st(), 32'h00000004);
    pipe.ctl_rd(1, q);
    chk("esaved", q, 32'h00000001);
    pipe.ctl_rd(7, q);
    chk("cause", q, {25'h0, exc_cause_code, 2'b00});
    ev(4'h2);
    chk("eret", st(), 32'h00000001);
    pipe.ctl_wr(0, 32'h00000005);
    ev(4'h4);
    chk("brk", st(), 32'h00000004);
    pipe.ctl_rd(2, q);
    chk("bsaved", q, 32'h00000005);
    pipe.ctl_rd(1, q);
    chk("esaved2", q, 32'h00000001);
    ev(4'h1);
    chk("bret", st(), 32'h00000005);
    pipe.ctl_wr(0, 32'h00000002);
    chk("user", st(), 32'h00000002);
    pipe.ctl_rd(0, q);
    chk("deny", {31'h0, access_denied}, 32'h00000001);
    chk("deny_data", q, 32'h00000000);
    ev(4'h8);
    chk("sup", st(), 32'h00000004);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    chk("rereset", st(), 32'h00000000);
    close_out;
  end
endmodule

bind ccr_regfile ccr_monitor mon (.sys_clk(sys_clk), .rst(rst),
  .rd_req(rd_req), .wr_req(wr_req), .reg_index(reg_index),
  .wr_data(wr_data), .exc_take(exc_take), .brk_take(brk_take),
  .exc_return(exc_return), .brk_return(brk_return), .rd_data(rd_data),
  .rd_valid(rd_valid), .access_denied(access_denied),
  .irq_request(irq_request), .user_mode(user_mode),
  .global_interrupt_enable(global_interrupt_enable),
  .exception_active_flag(exception_active_flag));
